// ==== rtl/spdc_top.sv ====
// Board I/O control register: serial RS-485 mode and printer data direction
`timescale 1ns/1ps
`default_nettype none
module spdc_top
    import spdc_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire spdc_io_req_t          io_req,
    output logic      [SPDC_REG_W-1:0] io_rdata,
    input  wire logic                  uart2_rts,
    output logic                       rs485_party_mode,
    output logic                       rs485_drv_en,
    input  wire logic [SPDC_PRN_W-1:0] prn_data_in,
    input  wire logic [SPDC_PRN_W-1:0] prn_wr_data,
    output logic      [SPDC_PRN_W-1:0] prn_data_out,
    output logic                       prn_data_oe,
    output logic      [SPDC_PRN_W-1:0] prn_rd_data
);
    ////////////////////////////////////////////////////////////////////
    logic                  hit;
    logic [SPDC_REG_W-1:0] ctrl_q;
    spdc_mode_t            mode;

    // Timing seen from the host: a write taken at one edge lands in the
    // register at that edge and reaches the direction pins at the next, so
    // the pins trail the strobe by two edges. Reads answer one edge after
    // the strobe and the byte then stands until the next read. The printer
    // pin copies are registered both ways and trail the pads by one edge.

    // Bits of the shared byte that this block owns and reads back
    localparam logic [SPDC_REG_W-1:0] OWN_MASK =
        (SPDC_REG_W'(8'h01) << SPDC_BIT_PARTY) | (SPDC_REG_W'(8'h01) << SPDC_BIT_PRN_IN);

    assign hit  = (io_req.addr == SPDC_REG_ADDR);
    assign mode = spdc_mode_t'(ctrl_q[SPDC_BIT_PARTY]);

    // clear on reset
    // Whole byte stored; software mirrors it since other bits are shared
    spdc_ctrl_reg #(
        .W (SPDC_REG_W)
    ) u_reg (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (io_req.wr && hit),
        .wdata   (io_req.wdata),
        .value   (ctrl_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Read back only the party-line mode bit and the printer direction bit; others belong elsewhere
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= SPDC_REG_RESET;
        end else if (io_req.rd && hit) begin
            io_rdata <= SPDC_REG_RESET;
            io_rdata[SPDC_BIT_PARTY]  <= ctrl_q[SPDC_BIT_PARTY];
            io_rdata[SPDC_BIT_PRN_IN] <= ctrl_q[SPDC_BIT_PRN_IN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode select
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs485_party_mode <= 1'b0;
        end else begin
            rs485_party_mode <= (mode == SPDC_PARTY_LINE);
        end
    end

    // Registered so a decode glitch never keys the shared pair
    // RTS steers direction; receive while not in party mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs485_drv_en <= 1'b0;
        end else begin
            rs485_drv_en <= (mode == SPDC_PARTY_LINE) && uart2_rts;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // printer data direction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prn_data_oe  <= 1'b1;
            prn_data_out <= '0;
            prn_rd_data  <= '0;
        end else begin
            prn_data_oe  <= !ctrl_q[SPDC_BIT_PRN_IN];
            prn_data_out <= prn_wr_data;
            prn_rd_data  <= prn_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks. A write shows at the pins two edges after it is taken: one
    // edge to store the byte, one more for the registered outputs.

    // Accepted write with the party-line bit set
    sequence seq_party_wr;
        io_req.wr && hit && io_req.wdata[SPDC_BIT_PARTY];
    endsequence

    // Accepted write with the party-line bit clear
    sequence seq_duplex_wr;
        io_req.wr && hit && !io_req.wdata[SPDC_BIT_PARTY];
    endsequence

    // Accepted write that turns the printer lines to inputs
    sequence seq_prn_in_wr;
        io_req.wr && hit && io_req.wdata[SPDC_BIT_PRN_IN];
    endsequence

    // Accepted write that hands the printer lines back to the block
    sequence seq_prn_out_wr;
        io_req.wr && hit && !io_req.wdata[SPDC_BIT_PRN_IN];
    endsequence

    // Accepted read of the control byte
    sequence seq_ctrl_rd;
        io_req.rd && hit;
    endsequence

    ////////////////////////////////////////////////////////////////////
    // Serial mode
    AST_WRITE_PARTY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_party_wr |=> ##1 rs485_party_mode)
        else $error("party mode not set after write");
    AST_WRITE_DUPLEX: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_duplex_wr |=> ##1 !rs485_party_mode)
        else $error("party mode kept after clearing write");
    AST_FULL_DUP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[SPDC_BIT_PARTY] |=> !rs485_party_mode)
        else $error("party mode without bit");
    AST_PARTY_SHOWN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[SPDC_BIT_PARTY] |=> rs485_party_mode)
        else $error("party bit not shown on mode pin");

    ////////////////////////////////////////////////////////////////////
    // Transceiver direction
    AST_RTS_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[SPDC_BIT_PARTY] && uart2_rts |=> rs485_drv_en)
        else $error("driver not enabled by rts");
    AST_RTS_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[SPDC_BIT_PARTY] && !uart2_rts |=> !rs485_drv_en)
        else $error("driver enabled without rts");
    AST_RX_DEFAULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[SPDC_BIT_PARTY] |=> !rs485_drv_en)
        else $error("driver enabled outside party mode");
    AST_DRV_IN_PARTY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rs485_drv_en |-> rs485_party_mode)
        else $error("driver enabled while mode pin shows full duplex");

    ////////////////////////////////////////////////////////////////////
    // Printer direction
    AST_PRN_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctrl_q[SPDC_BIT_PRN_IN] |=> prn_data_oe)
        else $error("printer data not driven");
    AST_PRN_IN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_prn_in_wr |=> ##1 !prn_data_oe)
        else $error("printer data not released");
    AST_PRN_BACK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_prn_out_wr |=> ##1 prn_data_oe)
        else $error("printer data not driven after clearing write");
    AST_PRN_RELEASED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q[SPDC_BIT_PRN_IN] |=> !prn_data_oe)
        else $error("printer data driven while set as input");

    // Pin copies run one edge behind, bit by bit
    for (genvar gi = 0; gi < SPDC_PRN_W; gi++) begin : g_prn_bit
        AST_PRN_DATA: assert property (@(posedge ref_clk) disable iff (!rst_n)
            1'b1 |=> prn_data_out[gi] == $past(prn_wr_data[gi]))
            else $error("printer output bit lost");
        AST_PRN_SAMPLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
            1'b1 |=> prn_rd_data[gi] == $past(prn_data_in[gi]))
            else $error("printer input bit lost");
    end

    ////////////////////////////////////////////////////////////////////
    // Register access
    AST_READ_BITS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        seq_ctrl_rd |=> io_rdata == ($past(ctrl_q) & OWN_MASK))
        else $error("read data differs from stored bits");
    AST_RDATA_OWN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (io_rdata & ~OWN_MASK) == SPDC_REG_RESET)
        else $error("read data shows bits owned elsewhere");
    AST_READ_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(io_req.rd && hit) |=> $stable(io_rdata))
        else $error("read data changed without a read");
    AST_STORE_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        io_req.wr && hit |=> ctrl_q == $past(io_req.wdata))
        else $error("written byte not stored");
    AST_MISS_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        io_req.wr && !hit |=> $stable(ctrl_q))
        else $error("register changed on other address");

    ////////////////////////////////////////////////////////////////////
    // Reset values are looked at one edge after reset is seen, so that a
    // power-up with no reset edge yet still starts from a clocked clear
    AST_RESET_CLEAR: assert property (@(posedge ref_clk)
        !rst_n |=> ctrl_q == SPDC_REG_RESET)
        else $error("register not cleared in reset");
    AST_RESET_DUPLEX: assert property (@(posedge ref_clk)
        !rst_n |=> !rs485_party_mode)
        else $error("party mode set out of reset");
    AST_RESET_RX: assert property (@(posedge ref_clk)
        !rst_n |=> !rs485_drv_en)
        else $error("driver enabled out of reset");
    AST_RESET_PRN: assert property (@(posedge ref_clk)
        !rst_n |=> prn_data_oe)
        else $error("printer data not driven out of reset");
endmodule
`default_nettype wire

// ==== shared/spdc_pkg.sv ====
// Package for the serial/printer direction control block
package spdc_pkg;
    localparam logic [9:0] SPDC_REG_ADDR     = 10'h201;
    localparam int         SPDC_REG_W        = 8;
    localparam int         SPDC_BIT_PARTY    = 3;
    localparam int         SPDC_BIT_PRN_IN   = 4;
    localparam logic [7:0] SPDC_REG_RESET    = 8'h00;
    localparam int         SPDC_PRN_W        = 8;

    // Host I/O write/read request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } spdc_io_req_t;

    // Mode selected for the second serial port transceiver
    typedef enum logic [0:0] {
        SPDC_FULL_DUPLEX = 1'b0,
        SPDC_PARTY_LINE  = 1'b1
    } spdc_mode_t;
endpackage

// ==== rtl/spdc_ctrl_reg.sv ====
// Control register storage, cleared by reset and loaded on write enable
`timescale 1ns/1ps
`default_nettype none
module spdc_ctrl_reg
    import spdc_pkg::*;
#(
    parameter int W = SPDC_REG_W
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] value
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= W'(SPDC_REG_RESET);
        end else if (wr_en) begin
            value <= wdata;
        end
    end
endmodule
`default_nettype wire

// ==== dv/spdc_host.sv ====
// Host software model: port I/O cycles and a mirror copy of the register
`timescale 1ns/1ps
`default_nettype none
module spdc_host
    import spdc_pkg::*;
(
    input  wire logic [7:0] io_rdata,
    input  wire logic       ref_clk,
    output var  spdc_io_req_t io_req
);
    logic [7:0] mirror_r = 8'h00;
    initial io_req = '0;
    task automatic wr_reg(input logic [7:0] v, input logic [9:0] a);
        @(negedge ref_clk);
        if (a == SPDC_REG_ADDR) mirror_r = v;
        io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(negedge ref_clk);
        io_req.wr = 1'b0;
    endtask
    task automatic rd_reg(output logic [7:0] v);
        @(negedge ref_clk);
        io_req = '{rd: 1'b1, wr: 1'b0, addr: SPDC_REG_ADDR, wdata: 8'h00};
        @(negedge ref_clk);
        io_req.rd = 1'b0;
        @(negedge ref_clk);
        v = io_rdata;
    endtask
endmodule
`default_nettype wire

// ==== dv/test_serial_printer_direction_ctrl.sv ====
// Testbench for the serial/printer direction control block
`timescale 1ns/1ps
`default_nettype none
module test_serial_printer_direction_ctrl;
    import spdc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, uart2_rts = 1'b1, party, drv, oe;
    logic [7:0] p_in = 8'hA5, p_wr = 8'h3C, p_out, p_rd, rdata, v;
    spdc_io_req_t io_req;
    int bad_count = 0, checks_done = 0, cyc = 0;
    always #4 ref_clk = ~ref_clk;
    spdc_host host_u (.io_rdata(rdata), .ref_clk(ref_clk), .io_req(io_req));
    spdc_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(rdata),
        .uart2_rts(uart2_rts), .rs485_party_mode(party), .rs485_drv_en(drv),
        .prn_data_in(p_in), .prn_wr_data(p_wr), .prn_data_out(p_out),
        .prn_data_oe(oe), .prn_rd_data(p_rd));
    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Hang guard, run needs under 200 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk({7'h00, party}, 8'h00);
        chk({7'h00, drv}, 8'h00);
        chk({7'h00, oe}, 8'h01);
        chk(p_out, 8'h3C);
        host_u.rd_reg(v);
        chk(v, 8'h00);
        // Near-miss address must not land
        host_u.wr_reg(8'h08, 10'h202);
        repeat (2) @(negedge ref_clk);
        chk({7'h00, party}, 8'h00);
        host_u.wr_reg(host_u.mirror_r | 8'h08, SPDC_REG_ADDR);
        repeat (2) @(negedge ref_clk);
        chk({7'h00, party}, 8'h01);
        chk({7'h00, drv}, 8'h01);
        uart2_rts = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({7'h00, drv}, 8'h00);
        host_u.wr_reg(host_u.mirror_r | 8'h10, SPDC_REG_ADDR);
        p_in = 8'h5A;
        p_wr = 8'hC3;
        repeat (2) @(negedge ref_clk);
        chk({7'h00, oe}, 8'h00);
        chk(p_rd, 8'h5A);
        chk(p_out, 8'hC3);
        chk({7'h00, party}, 8'h01);
        host_u.rd_reg(v);
        chk(v, 8'h18);
        uart2_rts = 1'b1;
        rst_n = 1'b0;
        @(negedge ref_clk);
        chk({6'h00, party, drv}, 8'h00);
        chk({7'h00, oe}, 8'h01);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk({6'h00, party, drv}, 8'h00);
        chk({7'h00, oe}, 8'h01);
        host_u.rd_reg(v);
        chk(v, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
